// File: hdl/csi_charger_status_indicator.sv
//Function
//- out-of-window temperature halts charge with fault; return starts fresh cycle
//- under-temperature flag sets on its set comparator, clears on clear comparator
//- over-temperature flag sets on its set comparator, clears on clear comparator
//- removal comparator high means battery absent; charging stops
//- removal clearing after insertion starts new charge cycle
//- charging status high only while charging
//- any fault stops charging, status low
//- fault cause selects eighth or ninth divider stage for first output
//- blink sources are 50% duty square waves
//- fast blink 256 oscillator periods, slow blink 512
//- first output: on charging, off done/disabled, slow temp, fast timeout
//- second output: on charging, off done/disabled, fast on any fault
//- bias output shows input power present
//- enable held low shuts down and turns bias off
//- timeout fault latches until power cycle or enable toggle
//- new cycle on reset, insertion, recharge, over-temp recovery, enable release
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module csi_charger_status_indicator
(
    // clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        rst_in,
    // analog front end
    input  wire logic        power_good_in,
    input  wire logic        enable_in,
    input  wire logic        ut_set_in,
    input  wire logic        ut_clr_in,
    input  wire logic        ot_set_in,
    input  wire logic        ot_clr_in,
    input  wire logic        removed_in,
    // apb slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // indication
    output logic             charging_out,
    output logic             status_output_first_out,
    output logic             status_output_first_oe_out,
    output logic             status_output_second_out,
    output logic             status_output_second_oe_out,
    output logic             bias_supply_output_out,
    output logic             irq_out
);
    // ************************************************************
    // declarations
    // ************************************************************
    csi_pkg::csi_state_t state_reg;
    csi_pkg::csi_state_t state_next;
    logic [31:0]              ctrl_reg;
    logic [31:0]              oscdiv_reg;
    logic [31:0]              timer_limit_reg;
    logic [31:0]              osc_cnt_reg;
    logic                     osc_tick;
    logic [csi_pkg::DIV_W-1:0] div_reg;
    logic [31:0]              timer_reg;
    logic                     ut_reg;
    logic                     ot_reg;
    logic                     ot_prev_reg;
    logic                     removed_prev_reg;
    logic                     enable_prev_reg;
    logic                     shutdown;
    logic                     temp_fault;
    logic                     start_evt;
    logic                     timeout_evt;
    logic [csi_pkg::IRQ_W-1:0] irq_reg;
    logic [csi_pkg::IRQ_W-1:0] mask_reg;
    logic [csi_pkg::IRQ_W-1:0] irq_set;
    logic                     wr_en;
    logic                     rd_en;
    logic                     first_next;
    logic                     second_next;

    assign wr_en = psel_in & penable_in & pwrite_in;
    assign rd_en = psel_in & penable_in & ~pwrite_in;
    assign shutdown = ~enable_in | ~ctrl_reg[csi_pkg::CTRL_SW_EN] | ~power_good_in;
    assign temp_fault = ut_reg | ot_reg;

    // ************************************************************
    // oscillator tick and divider chain
    // ************************************************************
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
            osc_cnt_reg <= 32'h0000_0000;
        else if (osc_tick)
            osc_cnt_reg <= 32'h0000_0000;
        else
            osc_cnt_reg <= osc_cnt_reg + 32'h0000_0001;
    end
    assign osc_tick = (osc_cnt_reg + 32'h0000_0001 >= oscdiv_reg);

    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
            div_reg <= '0;
        else if (osc_tick)
            div_reg <= div_reg + {{(csi_pkg::DIV_W-1){1'b0}}, 1'b1};
    end

    // ************************************************************
    // temperature comparators with hysteresis
    // ************************************************************
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ut_reg           <= 1'b0;
            ot_reg           <= 1'b0;
            ot_prev_reg      <= 1'b0;
            removed_prev_reg <= 1'b0;
            enable_prev_reg  <= 1'b1;
        end
        else
        begin
            if (ut_set_in)
                ut_reg <= 1'b1;
            else if (ut_clr_in)
                ut_reg <= 1'b0;
            if (ot_set_in)
                ot_reg <= 1'b1;
            else if (ot_clr_in)
                ot_reg <= 1'b0;
            ot_prev_reg      <= ot_reg;
            removed_prev_reg <= removed_in;
            enable_prev_reg  <= ~shutdown;
        end
    end

    // new cycle sources
    assign start_evt = (~enable_prev_reg & ~shutdown)
                     | (removed_prev_reg & ~removed_in)
                     | (ot_prev_reg & ~ot_reg)
                     | (state_reg == csi_pkg::CSI_DONE && ctrl_reg[csi_pkg::CTRL_RECHG]);
    assign timeout_evt = state_reg == csi_pkg::CSI_CHARGE && ctrl_reg[csi_pkg::CTRL_TO_EN]
                       && timer_reg >= timer_limit_reg;

    // ************************************************************
    // charge state machine
    // ************************************************************
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            csi_pkg::CSI_OFF:
                if (!shutdown)
                    state_next = csi_pkg::CSI_CHARGE;
            csi_pkg::CSI_CHARGE:
                if (timeout_evt)
                    state_next = csi_pkg::CSI_TOFAULT;
                else if (ctrl_reg[csi_pkg::CTRL_EOC])
                    state_next = csi_pkg::CSI_DONE;
            csi_pkg::CSI_DONE:
                if (start_evt)
                    state_next = csi_pkg::CSI_CHARGE;
            csi_pkg::CSI_TFAULT:
                if (!temp_fault)
                    state_next = csi_pkg::CSI_CHARGE;
            csi_pkg::CSI_REMOVED:
                if (!removed_in)
                    state_next = csi_pkg::CSI_CHARGE;
            csi_pkg::CSI_TOFAULT:
                state_next = csi_pkg::CSI_TOFAULT;
            default:
                state_next = csi_pkg::CSI_OFF;
        endcase
        if (state_reg != csi_pkg::CSI_OFF && state_reg != csi_pkg::CSI_TOFAULT
            && state_next != csi_pkg::CSI_TOFAULT)
        begin
            if (removed_in)
                state_next = csi_pkg::CSI_REMOVED;
            else if (temp_fault)
                state_next = csi_pkg::CSI_TFAULT;
            else if (start_evt && state_reg != csi_pkg::CSI_CHARGE)
                state_next = csi_pkg::CSI_CHARGE;
        end
        if (shutdown)
            state_next = csi_pkg::CSI_OFF;
    end

    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
            state_reg <= csi_pkg::CSI_OFF;
        else
            state_reg <= state_next;
    end

    // safety timer counts oscillator periods within a cycle
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
            timer_reg <= 32'h0000_0000;
        else if (state_next == csi_pkg::CSI_CHARGE && state_reg != csi_pkg::CSI_CHARGE)
            timer_reg <= 32'h0000_0000;
        else if (state_reg == csi_pkg::CSI_CHARGE && osc_tick)
            timer_reg <= timer_reg + 32'h0000_0001;
    end

    // ************************************************************
    // indication outputs
    // ************************************************************
    always_comb
    begin
        first_next  = 1'b0;
        second_next = 1'b0;
        case (state_reg)
            csi_pkg::CSI_CHARGE:
            begin
                first_next  = 1'b1;
                second_next = 1'b1;
            end
            csi_pkg::CSI_TFAULT, csi_pkg::CSI_REMOVED:
            begin
                first_next  = div_reg[csi_pkg::SLOW_TAP];
                second_next = div_reg[csi_pkg::FAST_TAP];
            end
            csi_pkg::CSI_TOFAULT:
            begin
                first_next  = div_reg[csi_pkg::FAST_TAP];
                second_next = div_reg[csi_pkg::FAST_TAP];
            end
            default:
            begin
                first_next  = 1'b0;
                second_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            charging_out                <= 1'b0;
            status_output_first_out     <= 1'b0;
            status_output_first_oe_out  <= 1'b0;
            status_output_second_out    <= 1'b0;
            status_output_second_oe_out <= 1'b0;
            bias_supply_output_out      <= 1'b0;
        end
        else
        begin
            charging_out                <= state_reg == csi_pkg::CSI_CHARGE;
            // open drain: pin pulled low (led on) while enabled
            status_output_first_out     <= 1'b0;
            status_output_first_oe_out  <= first_next;
            status_output_second_out    <= 1'b0;
            status_output_second_oe_out <= second_next;
            bias_supply_output_out      <= power_good_in & enable_in;
        end
    end

    // ************************************************************
    // interrupts and apb registers
    // ************************************************************
    assign irq_set[csi_pkg::IRQ_TEMP]    = state_next == csi_pkg::CSI_TFAULT && state_reg != csi_pkg::CSI_TFAULT;
    assign irq_set[csi_pkg::IRQ_REMOVE]  = state_next == csi_pkg::CSI_REMOVED && state_reg != csi_pkg::CSI_REMOVED;
    assign irq_set[csi_pkg::IRQ_TIMEOUT] = state_next == csi_pkg::CSI_TOFAULT && state_reg != csi_pkg::CSI_TOFAULT;
    assign irq_set[csi_pkg::IRQ_START]   = state_next == csi_pkg::CSI_CHARGE && state_reg != csi_pkg::CSI_CHARGE;
    assign irq_set[csi_pkg::IRQ_DONE]    = state_next == csi_pkg::CSI_DONE && state_reg != csi_pkg::CSI_DONE;

    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
            irq_reg <= '0;
        else if (wr_en && paddr_in == csi_pkg::ADDR_IRQ)
            irq_reg <= (irq_reg & ~pwdata_in[csi_pkg::IRQ_W-1:0]) | irq_set;
        else
            irq_reg <= irq_reg | irq_set;
    end

    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ctrl_reg        <= csi_pkg::CTRL_RESET;
            mask_reg        <= '0;
            timer_limit_reg <= csi_pkg::TMR_DEF;
            oscdiv_reg      <= csi_pkg::OSC_DIV_DEF;
        end
        else if (wr_en)
        begin
            if (paddr_in == csi_pkg::ADDR_CTRL)
                ctrl_reg <= pwdata_in;
            else if (paddr_in == csi_pkg::ADDR_MASK)
                mask_reg <= pwdata_in[csi_pkg::IRQ_W-1:0];
            else if (paddr_in == csi_pkg::ADDR_TIMER)
                timer_limit_reg <= pwdata_in;
            else if (paddr_in == csi_pkg::ADDR_OSCDIV)
                oscdiv_reg <= pwdata_in;
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            prdata_out  <= 32'h0000_0000;
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            irq_out     <= 1'b0;
        end
        else
        begin
            irq_out     <= |(irq_reg & mask_reg);
            pready_out  <= psel_in & ~penable_in;
            pslverr_out <= 1'b0;
            if (psel_in && !penable_in && !pwrite_in)
            begin
                if (paddr_in == csi_pkg::ADDR_CTRL)
                    prdata_out <= ctrl_reg;
                else if (paddr_in == csi_pkg::ADDR_STATUS)
                    prdata_out <= {26'h000_0000, ut_reg, ot_reg, removed_in, 3'(state_reg)};
                else if (paddr_in == csi_pkg::ADDR_IRQ)
                    prdata_out <= {27'h000_0000, irq_reg};
                else if (paddr_in == csi_pkg::ADDR_MASK)
                    prdata_out <= {27'h000_0000, mask_reg};
                else if (paddr_in == csi_pkg::ADDR_TIMER)
                    prdata_out <= timer_limit_reg;
                else if (paddr_in == csi_pkg::ADDR_OSCDIV)
                    prdata_out <= oscdiv_reg;
                else
                    prdata_out <= 32'h0000_0000;
            end
            else if (!rd_en)
                prdata_out <= 32'h0000_0000;
        end
    end
endmodule : csi_charger_status_indicator

// File: hdl/csi_pkg.sv
package csi_pkg;
    // ************************************************************
    // apb register map
    // ************************************************************
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ    = 8'h08;
    localparam logic [7:0] ADDR_MASK   = 8'h0C;
    localparam logic [7:0] ADDR_TIMER  = 8'h10;
    localparam logic [7:0] ADDR_OSCDIV = 8'h14;
    // ctrl fields
    localparam int CTRL_SW_EN  = 0;
    localparam int CTRL_TO_EN  = 1;
    localparam int CTRL_EOC    = 2;
    localparam int CTRL_RECHG  = 3;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0003;
    // irq fields
    localparam int IRQ_W        = 5;
    localparam int IRQ_TEMP     = 0;
    localparam int IRQ_REMOVE   = 1;
    localparam int IRQ_TIMEOUT  = 2;
    localparam int IRQ_START    = 3;
    localparam int IRQ_DONE     = 4;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int          DIV_W       = 22;
    localparam int          FAST_TAP    = 7;
    localparam int          SLOW_TAP    = 8;
    localparam logic [31:0] OSC_DIV_DEF = 32'h0000_0064;
    localparam logic [31:0] TMR_DEF     = 32'h0040_0000;
    typedef enum logic [2:0] {CSI_OFF, CSI_CHARGE, CSI_DONE, CSI_TFAULT, CSI_REMOVED, CSI_TOFAULT} csi_state_t;
endpackage : csi_pkg

// File: tb/csi_charger_status_indicator_bench.sv
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; $display("Error t=%0t got %h exp %h", $time, a, b); end end
module csi_charger_status_indicator_bench;
    // ************************************************************
    // signals and model state
    // ************************************************************
    logic        clk = 0, rst = 1, pg = 1, en = 1, psel = 0, pen = 0, pwr = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd, r, seed = 32'h388b_6398;
    logic        pready, pslverr, chg, s1, s1_oe, s2, s2_oe, bias, irq, ut_s, ut_c, ot_s, ot_c, rem, led1, led2;
    logic [15:0] mv = 16'h03E8;
    int          n_fail = 0, n_checks = 0, cyc = 0, hi, per, m_state;
    logic [15:0] f_mv[3] = '{16'h0708, 16'h01F4, 16'h09C4};
    logic [15:0] h_mv[3] = '{16'h0578, 16'h026C, 16'h0898};
    int          f_st[3] = '{3, 3, 4}, f_bit[3] = '{0, 0, 1};
    logic [7:0]  r_a[4] = '{csi_pkg::ADDR_CTRL, csi_pkg::ADDR_TIMER, csi_pkg::ADDR_OSCDIV, 8'h40};
    logic [31:0] r_v[4] = '{csi_pkg::CTRL_RESET, csi_pkg::TMR_DEF, csi_pkg::OSC_DIV_DEF, 32'h0000_0000};
    initial
    begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            n_fail++;
            report_and_stop();
        end
    end
    csi_charger_status_indicator i_csi_charger_status_indicator
    (
        .sys_clk_in(clk), .rst_in(rst), .power_good_in(pg), .enable_in(en), .ut_set_in(ut_s), .ut_clr_in(ut_c),
        .ot_set_in(ot_s), .ot_clr_in(ot_c), .removed_in(rem), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .charging_out(chg), .status_output_first_out(s1), .status_output_first_oe_out(s1_oe),
        .status_output_second_out(s2), .status_output_second_oe_out(s2_oe), .bias_supply_output_out(bias),
        .irq_out(irq)
    );
    csi_thermistor_led i_csi_thermistor_led
    (
        .mv_in(mv), .pin1_in(s1), .pin1_oe_in(s1_oe), .pin2_in(s2), .pin2_oe_in(s2_oe), .ut_set_out(ut_s),
        .ut_clr_out(ut_c), .ot_set_out(ot_s), .ot_clr_out(ot_c), .removed_out(rem), .led1_on_out(led1),
        .led2_on_out(led2)
    );
    // ************************************************************
    // tasks
    // ************************************************************
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 0;
        pen <= 0;
    endtask : apb
    task automatic chk(input logic [7:0] a, input logic [31:0] d);
        apb(0, a, 32'h0000_0000);
        `CHK(rd, d)
        `CHK(pslverr, 1'b0)
    endtask : chk
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_cyc
    task automatic set_mv(input logic [15:0] v);
        @(posedge clk);
        mv <= v;
        wait_cyc(4);
    endtask : set_mv
    task automatic state_is(input int s);
        m_state = s;
        apb(0, csi_pkg::ADDR_STATUS, 32'h0000_0000);
        `CHK(rd[2:0], 3'(m_state))
        `CHK(chg, m_state == 1)
    endtask : state_is
    task automatic blink(input logic w);
        hi = 0;
        @(negedge clk);
        while ((w ? led2 : led1) !== 1'b0) @(negedge clk);
        while ((w ? led2 : led1) !== 1'b1) @(negedge clk);
        for (hi = 0; (w ? led2 : led1) === 1'b1; hi++) @(negedge clk);
        for (per = hi; (w ? led2 : led1) === 1'b0; per++) @(negedge clk);
        `CHK(2 * hi, per)
    endtask : blink
    // ************************************************************
    // scenarios
    // ************************************************************
    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 0;
        for (int i = 0; i < 4; i++)
            chk(r_a[i], r_v[i]);
        apb(1, csi_pkg::ADDR_OSCDIV, 32'h0000_0001);
        apb(1, csi_pkg::ADDR_TIMER, 32'h0000_8000);
        apb(1, csi_pkg::ADDR_STATUS, 32'h0000_0000);
        state_is(1);
        `CHK({s1_oe, s2_oe, bias}, 3'b111)
        chk(csi_pkg::ADDR_IRQ, 32'h0000_0008);
        `CHK(irq, 1'b0)
        apb(1, csi_pkg::ADDR_MASK, 32'h0000_001F);
        wait_cyc(2);
        `CHK(irq, 1'b1)
        apb(1, csi_pkg::ADDR_IRQ, 32'h0000_001F);
        chk(csi_pkg::ADDR_IRQ, 32'h0000_0000);
        `CHK(irq, 1'b0)
        $display("test reset and irq done");
        for (int i = 0; i < 3; i++)
        begin
            apb(1, csi_pkg::ADDR_IRQ, 32'h0000_001F);
            set_mv(f_mv[i]);
            state_is(f_st[i]);
            blink(0);
            `CHK(per, 32'h0000_0200)
            blink(1);
            `CHK(per, 32'h0000_0100)
            apb(0, csi_pkg::ADDR_IRQ, 32'h0000_0000);
            `CHK({rd[f_bit[i]], irq}, 2'b11)
            set_mv(h_mv[i]);
            state_is(f_st[i]);
            set_mv(16'h03E8);
            state_is(1);
            $display("test fault %0d done", i);
        end
        for (int i = 0; i < 8; i++)
        begin
            r = xs();
            set_mv(16'h02BC + r[15:0] % 16'h01F4);
            apb(1, csi_pkg::ADDR_MASK, r);
            chk(csi_pkg::ADDR_MASK, {27'h000_0000, r[4:0]});
            state_is(1);
        end
        apb(1, csi_pkg::ADDR_MASK, 32'h0000_001F);
        apb(1, csi_pkg::ADDR_CTRL, 32'h0000_0007);
        wait_cyc(300);
        state_is(2);
        `CHK({led1, led2}, 2'b00)
        apb(0, csi_pkg::ADDR_IRQ, 32'h0000_0000);
        `CHK(rd[4], 1'b1)
        apb(1, csi_pkg::ADDR_CTRL, 32'h0000_000B);
        wait_cyc(4);
        state_is(1);
        apb(1, csi_pkg::ADDR_CTRL, 32'h0000_0003);
        @(posedge clk);
        pg <= 0;
        wait_cyc(4);
        `CHK(bias, 1'b0)
        state_is(0);
        @(posedge clk);
        pg <= 1;
        wait_cyc(4);
        state_is(1);
        $display("test done and power done");
        apb(1, csi_pkg::ADDR_TIMER, 32'h0000_0258);
        wait_cyc(800);
        state_is(5);
        blink(0);
        `CHK(per, 32'h0000_0100)
        blink(1);
        `CHK(per, 32'h0000_0100)
        set_mv(16'h0708);
        set_mv(16'h03E8);
        state_is(5);
        apb(1, csi_pkg::ADDR_TIMER, 32'h0000_8000);
        @(posedge clk);
        en <= 0;
        wait_cyc(4);
        `CHK({bias, led1, led2}, 3'b000)
        state_is(0);
        @(posedge clk);
        en <= 1;
        wait_cyc(4);
        state_is(1);
        apb(1, csi_pkg::ADDR_CTRL, 32'h0000_0002);
        wait_cyc(4);
        state_is(0);
        apb(1, csi_pkg::ADDR_CTRL, 32'h0000_0001);
        apb(1, csi_pkg::ADDR_TIMER, 32'h0000_0010);
        wait_cyc(40);
        state_is(1);
        apb(1, csi_pkg::ADDR_TIMER, 32'h0000_8000);
        apb(1, csi_pkg::ADDR_CTRL, 32'h0000_0003);
        $display("test timeout done");
        report_and_stop();
    end
endmodule : csi_charger_status_indicator_bench

// File: tb/csi_checker.sv
`timescale 1ns/10ps
module csi_checker
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // watched ports
    input wire logic power_good_in,
    input wire logic enable_in,
    input wire logic ut_set_in,
    input wire logic ot_set_in,
    input wire logic removed_in,
    input wire logic charging_out,
    input wire logic status_output_first_out,
    input wire logic status_output_first_oe_out,
    input wire logic status_output_second_out,
    input wire logic status_output_second_oe_out,
    input wire logic bias_supply_output_out
);
    // ************************************************************
    // properties
    // ************************************************************
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);
    sequence s_charging;
        charging_out ##1 charging_out;
    endsequence
    sequence s_released;
        $rose(enable_in) && power_good_in && !removed_in && !ut_set_in && !ot_set_in;
    endsequence
    a_cold_stops: assert property (ut_set_in |-> ##[1:3] !charging_out)
        else $error("charging kept on while cold");
    a_hot_stops: assert property (ot_set_in |-> ##[1:3] !charging_out)
        else $error("charging kept on while hot");
    a_removal_stops: assert property (removed_in |-> ##[1:3] !charging_out)
        else $error("charging kept on with battery absent");
    a_led_on: assert property (s_charging |-> status_output_first_oe_out && status_output_second_oe_out)
        else $error("leds dark while charging");
    a_disabled_off: assert property (!enable_in [*3] |-> !(charging_out || status_output_first_oe_out
        || status_output_second_oe_out))
        else $error("activity while disabled");
    a_bias_power: assert property (1'b1 |=> bias_supply_output_out == $past(power_good_in && enable_in))
        else $error("bias output wrong");
    a_pin_sinks: assert property (!status_output_first_out && !status_output_second_out)
        else $error("status pin driven high");
    a_enable_restart: assert property (s_released |-> ##[1:4] charging_out)
        else $error("no charge after enable release");
endmodule : csi_checker
bind csi_charger_status_indicator csi_checker i_csi_checker
(
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .power_good_in(power_good_in), .enable_in(enable_in),
    .ut_set_in(ut_set_in), .ot_set_in(ot_set_in), .removed_in(removed_in), .charging_out(charging_out),
    .status_output_first_out(status_output_first_out), .status_output_first_oe_out(status_output_first_oe_out),
    .status_output_second_out(status_output_second_out),
    .status_output_second_oe_out(status_output_second_oe_out), .bias_supply_output_out(bias_supply_output_out)
);

// File: tb/csi_thermistor_led.sv
`timescale 1ns/10ps
module csi_thermistor_led
(
    // thermistor divider voltage in millivolts
    input  wire logic [15:0] mv_in,
    // open-drain led pins
    input  wire logic        pin1_in,
    input  wire logic        pin1_oe_in,
    input  wire logic        pin2_in,
    input  wire logic        pin2_oe_in,
    // comparator flags
    output logic             ut_set_out,
    output logic             ut_clr_out,
    output logic             ot_set_out,
    output logic             ot_clr_out,
    output logic             removed_out,
    // led states
    output logic             led1_on_out,
    output logic             led2_on_out
);
    assign ut_set_out  = mv_in > 16'h05DC;
    assign ut_clr_out  = mv_in < 16'h0506;
    assign ot_set_out  = mv_in < 16'h025D;
    assign ot_clr_out  = mv_in > 16'h0294;
    assign removed_out = mv_in >= 16'h0834;
    // the led pulls an undriven pin high; it lights only while the pin sinks
    assign led1_on_out = !(pin1_oe_in ? pin1_in : 1'b1);
    assign led2_on_out = !(pin2_oe_in ? pin2_in : 1'b1);
endmodule : csi_thermistor_led
